/* File: verilog/ifd_map.svh */
`ifndef IFD_MAP_SVH
`define IFD_MAP_SVH

`define IFD_OPC_HI    15
`define IFD_OPC_LO    12
`define IFD_DST_HI    11
`define IFD_DST_LO    8
`define IFD_SRC_HI    7
`define IFD_SRC_LO    4
`define IFD_SUB_HI    3
`define IFD_SUB_LO    0
`define IFD_D4_HI     3
`define IFD_D8_HI     7
`define IFD_D12_HI    11
`define IFD_SZ_HI     9
`define IFD_SZ_LO     8
`define IFD_SZ_BYTE   2'h0
`define IFD_SZ_WORD   2'h1
`define IFD_SZ_LONG   2'h2
`define IFD_REG_ZERO  4'h0
`define IFD_TRAP_SH   2
`define IFD_RST_VALID 1'h0

`endif

/* File: verilog/ifd_pkg.sv */
package ifd_pkg;

  typedef enum logic [3:0] {
    IFD_F_0    = 4'h0,
    IFD_F_N    = 4'h1,
    IFD_F_M    = 4'h2,
    IFD_F_NM   = 4'h3,
    IFD_F_MD   = 4'h4,
    IFD_F_ND4  = 4'h5,
    IFD_F_NMD  = 4'h6,
    IFD_F_D    = 4'h7,
    IFD_F_D12  = 4'h8,
    IFD_F_ND8  = 4'h9,
    IFD_F_I    = 4'hA,
    IFD_F_NI   = 4'hB
  } ifd_fmt_e;

  typedef enum logic [3:0] {
    IFD_M_NONE    = 4'h0,
    IFD_M_DIR     = 4'h1,
    IFD_M_IND     = 4'h2,
    IFD_M_POSTINC = 4'h3,
    IFD_M_PREDEC  = 4'h4,
    IFD_M_DISP    = 4'h5,
    IFD_M_IDX     = 4'h6,
    IFD_M_GLBDISP = 4'h7,
    IFD_M_GLBIDX  = 4'h8,
    IFD_M_PCDISP  = 4'h9,
    IFD_M_PCREL   = 4'hA,
    IFD_M_IMM     = 4'hB,
    IFD_M_CTRL    = 4'hC,
    IFD_M_MAC     = 4'hD
  } ifd_mode_e;

  typedef enum logic [1:0] {
    IFD_I_NONE = 2'h0,
    IFD_I_ZERO = 2'h1,
    IFD_I_SIGN = 2'h2,
    IFD_I_TRAP = 2'h3
  } ifd_imm_e;

  typedef enum logic [2:0] {
    IFD_D_NONE = 3'h0,
    IFD_D_D4   = 3'h1,
    IFD_D_D8Z  = 3'h2,
    IFD_D_D8S  = 3'h3,
    IFD_D_D12  = 3'h4
  } ifd_disp_e;

  typedef struct packed {
    ifd_imm_e   immKind;
    ifd_disp_e  dispKind;
    logic [1:0] size;
    logic       pcMask;
  } ifd_extctl_s;

  typedef struct packed {
    logic [31:0] imm;
    logic [31:0] disp;
    logic [31:0] target;
  } ifd_ext_s;

  typedef struct packed {
    ifd_fmt_e    fmt;
    ifd_mode_e   srcMode;
    ifd_mode_e   dstMode;
    logic [3:0]  srcReg;
    logic [3:0]  dstReg;
    logic [1:0]  size;
    logic        idxRegZero;
    logic        macDest;
    logic        illegal;
    logic [31:0] imm;
    logic [31:0] disp;
    logic [31:0] target;
  } ifd_dec_s;

  typedef struct packed {
    logic     valid;
    ifd_dec_s dec;
  } ifd_state_s;

endpackage

/* File: verilog/ifd_field_ext.sv */
`include "ifd_map.svh"

module ifd_field_ext (
  input  logic [15:0]          word,
  input  logic [31:0]          pc,
  input  ifd_pkg::ifd_extctl_s ctl,
  output ifd_pkg::ifd_ext_s    ext
);
  import ifd_pkg::*;

  // byte, word, longword scale by 1, 2, 4
  function automatic logic [31:0] scaleOff(input logic [31:0] v, input logic [1:0] sz);
    case (sz)
      `IFD_SZ_WORD: scaleOff = {v[30:0], 1'h0};
      `IFD_SZ_LONG: scaleOff = {v[29:0], 2'h0};
      default:      scaleOff = v;
    endcase
  endfunction

  logic [31:0] base;

  always_comb begin
    ext  = '0;
    base = ctl.pcMask ? {pc[31:2], 2'h0} : pc;
    case (ctl.immKind)
      IFD_I_ZERO: ext.imm = {24'h0, word[`IFD_D8_HI:0]};
      IFD_I_SIGN: ext.imm = {{24{word[`IFD_D8_HI]}}, word[`IFD_D8_HI:0]};
      IFD_I_TRAP: ext.imm = {22'h0, word[`IFD_D8_HI:0], 2'h0};
      default:    ext.imm = '0;
    endcase
    case (ctl.dispKind)
      IFD_D_D4:  ext.disp = scaleOff({28'h0, word[`IFD_D4_HI:0]}, ctl.size);
      IFD_D_D8Z: ext.disp = scaleOff({24'h0, word[`IFD_D8_HI:0]}, ctl.size);
      IFD_D_D8S: ext.disp = {{23{word[`IFD_D8_HI]}}, word[`IFD_D8_HI:0], 1'h0};
      IFD_D_D12: ext.disp = {{19{word[`IFD_D12_HI]}}, word[`IFD_D12_HI:0], 1'h0};
      default:   ext.disp = '0;
    endcase
    // target is only meaningful for pc-based modes; computed always to keep it one adder
    ext.target = 32'(base + ext.disp);
  end

endmodule

/* File: verilog/ifd_decoder.sv */
`include "ifd_map.svh"

module ifd_decoder (
  input  logic              clk_sys,
  input  logic              rst,
  input  logic              inValid,
  input  logic              inStall,
  input  logic [15:0]       inWord,
  input  logic [31:0]       inPc,
  output logic              outValid,
  output ifd_pkg::ifd_dec_s outDec
);
  import ifd_pkg::*;

  ifd_state_s  st_ff;
  ifd_state_s  nxt_st;
  ifd_extctl_s ctl;
  ifd_ext_s    ext;
  ifd_dec_s    d;
  logic [3:0]  opc;
  logic [3:0]  fN;
  logic [3:0]  fM;
  logic [3:0]  sub;
  logic [1:0]  szHi;

  assign opc  = inWord[`IFD_OPC_HI:`IFD_OPC_LO];
  assign fN   = inWord[`IFD_DST_HI:`IFD_DST_LO];
  assign fM   = inWord[`IFD_SRC_HI:`IFD_SRC_LO];
  assign sub  = inWord[`IFD_SUB_HI:`IFD_SUB_LO];
  assign szHi = inWord[`IFD_SZ_HI:`IFD_SZ_LO];

  ifd_field_ext u_ext (
    .word (inWord),
    .pc   (inPc),
    .ctl  (ctl),
    .ext  (ext)
  );

  // modes depend on opcode, sub and register-field bits; register numbers pass through except where a form swaps or zeroes them
  always_comb begin
    d         = '0;
    ctl       = '0;
    d.dstReg  = fN;
    d.srcReg  = fM;
    case (opc)
      4'h0: begin
        d.fmt = IFD_F_NM;
        d.size = sub[1:0];
        case (sub)
          4'h4, 4'h5, 4'h6: begin
            d.srcMode = IFD_M_DIR;
            d.dstMode = IFD_M_IDX;
            d.idxRegZero = 1'h1;
          end
          4'hC, 4'hD, 4'hE: begin
            d.srcMode = IFD_M_IDX;
            d.dstMode = IFD_M_DIR;
            d.idxRegZero = 1'h1;
          end
          4'h7: begin
            d.srcMode = IFD_M_DIR;
            d.dstMode = IFD_M_DIR;
          end
          4'hF: begin
            d.srcMode = IFD_M_POSTINC;
            d.dstMode = IFD_M_POSTINC;
            d.macDest = 1'h1;
            d.size    = `IFD_SZ_LONG;
          end
          4'h2, 4'hA: begin
            d.fmt     = IFD_F_N;
            d.srcMode = IFD_M_CTRL;
            d.dstMode = IFD_M_DIR;
          end
          4'h3: begin
            d.fmt     = IFD_F_M;
            d.srcReg  = fN;
            d.srcMode = IFD_M_PCREL;
          end
          4'h9: begin
            d.fmt     = (fM == 4'h2) ? IFD_F_N : IFD_F_0;
            d.dstMode = (fM == 4'h2) ? IFD_M_DIR : IFD_M_NONE;
          end
          4'h8, 4'hB: d.fmt = IFD_F_0;
          default: begin
            d.fmt     = IFD_F_0;
            d.illegal = 1'h1;
          end
        endcase
      end
      4'h1, 4'h5: begin
        d.fmt        = IFD_F_NMD;
        d.size       = `IFD_SZ_LONG;
        d.srcMode    = (opc == 4'h1) ? IFD_M_DIR : IFD_M_DISP;
        d.dstMode    = (opc == 4'h1) ? IFD_M_DISP : IFD_M_DIR;
        ctl.dispKind = IFD_D_D4;
      end
      4'h2: begin
        d.fmt     = IFD_F_NM;
        d.size    = sub[1:0];
        d.srcMode = IFD_M_DIR;
        case (sub)
          4'h0, 4'h1, 4'h2: d.dstMode = IFD_M_IND;
          4'h4, 4'h5, 4'h6: d.dstMode = IFD_M_PREDEC;
          4'h3:             d.illegal = 1'h1;
          default:          d.dstMode = IFD_M_DIR;
        endcase
      end
      4'h3: begin
        d.fmt     = IFD_F_NM;
        d.srcMode = IFD_M_DIR;
        d.dstMode = IFD_M_DIR;
      end
      4'h4: begin
        case (sub)
          4'hF: begin
            d.fmt     = IFD_F_NM;
            d.srcMode = IFD_M_POSTINC;
            d.dstMode = IFD_M_POSTINC;
            d.macDest = 1'h1;
            d.size    = `IFD_SZ_WORD;
          end
          4'h6, 4'h7: begin
            d.fmt     = IFD_F_M;
            d.srcReg  = fN;
            d.srcMode = IFD_M_POSTINC;
            d.dstMode = IFD_M_CTRL;
            d.size    = `IFD_SZ_LONG;
          end
          4'h2, 4'h3: begin
            d.fmt     = IFD_F_N;
            d.srcMode = IFD_M_CTRL;
            d.dstMode = IFD_M_PREDEC;
            d.size    = `IFD_SZ_LONG;
          end
          4'hA, 4'hE, 4'hB: begin
            d.fmt     = IFD_F_M;
            d.srcReg  = fN;
            d.srcMode = IFD_M_DIR;
            d.dstMode = (sub == 4'hB) ? IFD_M_NONE : IFD_M_CTRL;
          end
          default: begin
            d.fmt     = IFD_F_N;
            d.dstMode = IFD_M_DIR;
          end
        endcase
      end
      4'h6: begin
        d.fmt     = IFD_F_NM;
        d.size    = sub[1:0];
        d.dstMode = IFD_M_DIR;
        case (sub)
          4'h0, 4'h1, 4'h2: d.srcMode = IFD_M_IND;
          4'h4, 4'h5, 4'h6: d.srcMode = IFD_M_POSTINC;
          default:          d.srcMode = IFD_M_DIR;
        endcase
      end
      4'h7, 4'hE: begin
        d.fmt       = IFD_F_NI;
        d.srcMode   = IFD_M_IMM;
        d.dstMode   = IFD_M_DIR;
        ctl.immKind = IFD_I_SIGN;
      end
      4'h8: begin
        case (fN)
          4'h0, 4'h1: begin
            d.fmt        = IFD_F_ND4;
            d.size       = szHi;
            d.srcReg     = `IFD_REG_ZERO;
            d.dstReg     = fM;
            d.srcMode    = IFD_M_DIR;
            d.dstMode    = IFD_M_DISP;
            ctl.dispKind = IFD_D_D4;
          end
          4'h4, 4'h5: begin
            d.fmt        = IFD_F_MD;
            d.size       = szHi;
            d.dstReg     = `IFD_REG_ZERO;
            d.srcMode    = IFD_M_DISP;
            d.dstMode    = IFD_M_DIR;
            ctl.dispKind = IFD_D_D4;
          end
          4'h8: begin
            d.fmt       = IFD_F_I;
            d.srcMode   = IFD_M_IMM;
            d.dstMode   = IFD_M_DIR;
            d.dstReg    = `IFD_REG_ZERO;
            ctl.immKind = IFD_I_SIGN;
          end
          4'h9, 4'hB, 4'hD, 4'hF: begin
            d.fmt        = IFD_F_D;
            d.srcMode    = IFD_M_PCREL;
            ctl.dispKind = IFD_D_D8S;
          end
          default: d.illegal = 1'h1;
        endcase
      end
      4'h9, 4'hD: begin
        d.fmt        = IFD_F_ND8;
        d.size       = (opc == 4'h9) ? `IFD_SZ_WORD : `IFD_SZ_LONG;
        d.srcMode    = IFD_M_PCDISP;
        d.dstMode    = IFD_M_DIR;
        ctl.dispKind = IFD_D_D8Z;
        ctl.pcMask   = (opc == 4'hD);
      end
      4'hA, 4'hB: begin
        d.fmt        = IFD_F_D12;
        d.srcMode    = IFD_M_PCREL;
        ctl.dispKind = IFD_D_D12;
      end
      4'hC: begin
        d.srcReg = `IFD_REG_ZERO;
        d.dstReg = `IFD_REG_ZERO;
        d.size   = szHi;
        case (fN)
          4'h0, 4'h1, 4'h2: begin
            d.fmt        = IFD_F_D;
            d.srcMode    = IFD_M_DIR;
            d.dstMode    = IFD_M_GLBDISP;
            ctl.dispKind = IFD_D_D8Z;
          end
          4'h4, 4'h5, 4'h6: begin
            d.fmt        = IFD_F_D;
            d.srcMode    = IFD_M_GLBDISP;
            d.dstMode    = IFD_M_DIR;
            ctl.dispKind = IFD_D_D8Z;
          end
          4'h3: begin
            d.fmt       = IFD_F_I;
            d.srcMode   = IFD_M_IMM;
            ctl.immKind = IFD_I_TRAP;
          end
          4'h7: begin
            d.fmt        = IFD_F_D;
            d.size       = `IFD_SZ_LONG;
            d.srcMode    = IFD_M_PCDISP;
            d.dstMode    = IFD_M_DIR;
            ctl.dispKind = IFD_D_D8Z;
            ctl.pcMask   = 1'h1;
          end
          4'h8, 4'h9, 4'hA, 4'hB: begin
            d.fmt       = IFD_F_I;
            d.size      = `IFD_SZ_LONG;
            d.srcMode   = IFD_M_IMM;
            d.dstMode   = IFD_M_DIR;
            ctl.immKind = IFD_I_ZERO;
          end
          default: begin
            d.fmt       = IFD_F_I;
            d.size      = `IFD_SZ_BYTE;
            d.srcMode   = IFD_M_IMM;
            d.dstMode   = IFD_M_GLBIDX;
            d.idxRegZero = 1'h1;
            ctl.immKind = IFD_I_ZERO;
          end
        endcase
      end
      default: d.illegal = 1'h1;
    endcase
    ctl.size = d.size;
  end

  // a stalled datapath keeps the last decode so no word is lost while it waits
  always_comb begin
    nxt_st = st_ff;
    if (!inStall) begin
      nxt_st.valid = inValid;
      if (inValid) begin
        nxt_st.dec        = d;
        nxt_st.dec.imm    = ext.imm;
        nxt_st.dec.disp   = ext.disp;
        nxt_st.dec.target = ext.target;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      st_ff <= '{valid: `IFD_RST_VALID, dec: '0};
    end else begin
      st_ff <= nxt_st;
    end
  end
  assign outValid = st_ff.valid;
  assign outDec   = st_ff.dec;

endmodule

/* File: verification/ifd_decoder_checker.sv */
module ifd_decoder_checker (
  input logic              clk_sys,
  input logic              rst,
  input logic              inValid,
  input logic              inStall,
  input logic [15:0]       inWord,
  input logic [31:0]       inPc,
  input logic              outValid,
  input ifd_pkg::ifd_dec_s outDec
);
  timeunit 1ns;
  timeprecision 1ps;
  import ifd_pkg::*;
  logic take;
  assign take = inValid && !inStall;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  chk_lat_one: assert property (take |=> outValid)
    else $error("accepted word gave no output");
  chk_idle_low: assert property (!inValid && !inStall |=> !outValid)
    else $error("output valid without a word");
  chk_stall_hold: assert property (inStall |=> $stable(outValid) && $stable(outDec))
    else $error("output moved during stall");
  chk_nm_fields: assert property (take && inWord[15:12] == 4'h6
    && inWord[3:0] == 4'h6
    |=> outDec.dstReg == $past(inWord[11:8]) && outDec.srcReg == $past(inWord[7:4]))
    else $error("register fields misplaced");
  chk_index_zero: assert property (take && inWord[15:12] == 4'h0
    && inWord[3:0] inside {4'h4, 4'h5, 4'h6}
    |=> outDec.idxRegZero && outDec.dstMode == IFD_M_IDX)
    else $error("indexed destination not flagged");
  chk_mac_dest: assert property (take && inWord[3:0] == 4'hF
    && inWord[15:12] inside {4'h0, 4'h4}
    |=> outDec.macDest && outDec.dstMode == IFD_M_POSTINC)
    else $error("multiply-accumulate not flagged");
  chk_illegal_top: assert property (take && inWord[15:12] == 4'hF |=> outDec.illegal)
    else $error("unused opcode not refused");
  chk_logic_zext: assert property (take && inWord[15:11] == 5'h19
    |=> outDec.imm == {24'h0, $past(inWord[7:0])})
    else $error("logical immediate not zero-extended");
  chk_add_sext: assert property (take && inWord[15:12] == 4'h7
    |=> outDec.imm == {{24{$past(inWord[7])}}, $past(inWord[7:0])})
    else $error("add immediate not sign-extended");
  chk_bra_target: assert property (take && inWord[15:13] == 3'h5
    |=> outDec.target == $past(inPc) + {{19{$past(inWord[11])}}, $past(inWord[11:0]), 1'b0})
    else $error("branch target wrong");
  chk_d4_scale: assert property (take && inWord[15:9] == 7'h40
    |=> outDec.disp == ({28'h0, $past(inWord[3:0])} << $past(inWord[8])))
    else $error("short displacement badly scaled");

  cover property (take ##1 inStall && outValid);
  cover property (take && inWord[15:12] == 4'hF);
  cover property (take && inWord[15:12] == 4'h4 && inWord[3:0] == 4'hF);
endmodule

bind ifd_decoder ifd_decoder_checker chk_u (
  .clk_sys  (clk_sys),
  .rst      (rst),
  .inValid  (inValid),
  .inStall  (inStall),
  .inWord   (inWord),
  .inPc     (inPc),
  .outValid (outValid),
  .outDec   (outDec)
);

/* File: verification/ifd_fetch_model.sv */
module ifd_fetch_model (
  input  logic        clk_sys,
  input  logic        rst,
  input  logic        slow,
  output logic        inValid,
  output logic        inStall,
  output logic [15:0] inWord,
  output logic [31:0] inPc
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [47:0] q[$];

  task automatic push(input logic [47:0] e);
    q.push_back(e);
  endtask

  initial begin
    inValid = 1'b0;
    inStall = 1'b0;
    inWord = 16'h0;
    inPc = 32'h0;
  end

  // the word stays put until taken, since a stalled decoder does not buffer it
  always @(posedge clk_sys) begin
    if (rst) begin
      inValid <= 1'b0;
      inStall <= 1'b0;
    end else begin
      if (inValid && !inStall && q.size() > 0) begin
        void'(q.pop_front());
      end
      inStall <= slow && ($urandom_range(3) == 0);
      if (q.size() > 0) begin
        inValid <= 1'b1;
        inWord <= q[0][15:0];
        inPc <= q[0][47:16];
      end else begin
        // idle lines toggle so a stale word is never mistaken for a live one
        inValid <= 1'b0;
        inWord <= ~inWord;
        inPc <= ~inPc;
      end
    end
  end
endmodule

/* File: verification/ifd_decoder_tb_top.sv */
module ifd_decoder_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import ifd_pkg::*;
  localparam logic [31:0] CLS [17] = '{32'h6006F00F, 32'h0004F00F, 32'h0005F00F,
    32'h0006F00F, 32'h400FF00F, 32'h000FF00F, 32'h7000F000, 32'hE000F000, 32'hC800F800,
    32'hC300FF00, 32'hA000E000, 32'h8900F900, 32'h8000FE00, 32'h5000F000, 32'hF000F000,
    32'h9000F000, 32'hD000F000};
  localparam logic [15:0] CORNER [12] = '{16'h6106, 16'hA7FF, 16'hA800, 16'h0FF6,
    16'h400F, 16'h7080, 16'hE07F, 16'hC8FF, 16'hC3FF, 16'h89FF, 16'h81FF, 16'h5FFF};
  logic        clk_sys;
  logic        rst;
  logic        slow;
  logic        inValid;
  logic        inStall;
  logic [15:0] inWord;
  logic [31:0] inPc;
  logic        outValid;
  ifd_dec_s    outDec;
  logic [47:0] expQ[$];
  logic [47:0] sbE;
  logic [31:0] cl;
  int          nFail;
  int          checks;
  int          cycles;

  ifd_fetch_model fetch_u (.clk_sys(clk_sys), .rst(rst), .slow(slow), .inValid(inValid),
    .inStall(inStall), .inWord(inWord), .inPc(inPc));
  ifd_decoder dut_u (.clk_sys(clk_sys), .rst(rst), .inValid(inValid), .inStall(inStall),
    .inWord(inWord), .inPc(inPc), .outValid(outValid), .outDec(outDec));

  initial clk_sys = 1'b0;
  always #5 clk_sys = ~clk_sys;

  task automatic cmp(input logic [127:0] seen, input logic [127:0] exp);
    checks++;
    if (seen !== exp) begin
      nFail++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic conclude();
    $display("checks %0d mismatches %0d", checks, nFail);
    if (nFail == 0 && checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  task automatic send(input logic [15:0] w, input logic [31:0] pc);
    fetch_u.push({pc, w});
    expQ.push_back({pc, w});
  endtask

  // the sum wraps at 32 bits like the program counter; a wide compare would keep the carry
  function automatic logic [31:0] pcRel(input logic [31:0] base, input logic [31:0] off);
    return 32'(base + off);
  endfunction

  task automatic expect_dec(input logic [15:0] w, input logic [31:0] pc, input ifd_dec_s d);
    logic [31:0] s8;
    logic [31:0] s12;
    s8 = {{24{w[7]}}, w[7:0]};
    s12 = {{20{w[11]}}, w[11:0]};
    casez (w)
      16'h6??6: cmp({d.fmt, d.srcMode, d.dstMode, d.size},
        {IFD_F_NM, IFD_M_POSTINC, IFD_M_DIR, 2'h2});
      16'h0??4, 16'h0??5, 16'h0??6: cmp({d.srcMode, d.srcReg, d.size},
        {IFD_M_DIR, w[7:4], w[1:0]});
      16'h4??F, 16'h0??F: cmp({d.srcMode, d.srcReg, d.dstReg},
        {IFD_M_POSTINC, w[7:4], w[11:8]});
      16'hE???: cmp({d.dstReg, d.imm}, {w[11:8], s8});
      16'hC3??: cmp(d.imm, {22'h0, w[7:0], 2'h0});
      16'b1100_1???_????_????: cmp(d.imm, {24'h0, w[7:0]});
      16'hA???, 16'hB???: begin
        cmp({d.fmt, d.disp}, {IFD_F_D12, s12 << 1});
        cmp(d.target, pcRel(pc, s12 << 1));
      end
      16'b1000_1??1_????_????: cmp(d.target, pcRel(pc, s8 << 1));
      16'h5???: cmp(d.disp, {26'h0, w[3:0], 2'h0});
      16'h9???: cmp(d.target, pcRel(pc, {23'h0, w[7:0], 1'h0}));
      16'hD???: cmp(d.target, pcRel({pc[31:2], 2'h0}, {22'h0, w[7:0], 2'h0}));
      default: ;
    endcase
    cmp(d.illegal, w[15:12] == 4'hF);
  endtask

  task automatic drain();
    repeat (3000) if (expQ.size() != 0) @(posedge clk_sys);
    cmp(expQ.size(), 0);
    @(negedge clk_sys);
  endtask

  // scoreboard: an output counts once, at the edge where the datapath takes it
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 20000) begin
      nFail++;
      conclude();
    end
    if (!rst && outValid && !inStall) begin
      cmp(expQ.size() != 0, 1);
      if (expQ.size() != 0) begin
        sbE = expQ.pop_front();
        expect_dec(sbE[15:0], sbE[47:16], outDec);
      end
    end
  end

  initial begin
    rst = 1'b1;
    slow = 1'b0;
    nFail = 0;
    checks = 0;
    cycles = 0;
    void'($urandom(63));
    repeat (10) @(posedge clk_sys);
    rst <= 1'b0;
    @(negedge clk_sys);
    cmp({outValid, 121'(outDec)}, 0);
    foreach (CORNER[i]) send(CORNER[i], 32'h64);
    drain();
    @(posedge clk_sys);
    slow <= 1'b1;
    @(negedge clk_sys);
    repeat (400) begin
      cl = CLS[$urandom_range(16)];
      send(cl[31:16] | (16'($urandom) & ~cl[15:0]), $urandom & 32'hFFFFFFFE);
    end
    drain();
    @(posedge clk_sys);
    rst <= 1'b1;
    repeat (2) @(posedge clk_sys);
    rst <= 1'b0;
    @(negedge clk_sys);
    cmp({outValid, 121'(outDec)}, 0);
    send(16'h6106, 32'h0);
    drain();
    conclude();
  end
endmodule
